// ===== rtl/gpio_pkg.sv
// Constants, register map and field layout of the general purpose I/O block
package gpioa_pkg;
  localparam int W = 8;
  localparam int AW = 8;
  // Register byte offsets
  localparam logic [AW-1:0] OFS_PA_DATA = 8'h00;
  localparam logic [AW-1:0] OFS_PB_DATA = 8'h04;
  localparam logic [AW-1:0] OFS_PC_DATA = 8'h08;
  localparam logic [AW-1:0] OFS_PD_DATA = 8'h0c;
  localparam logic [AW-1:0] OFS_PA_DIR  = 8'h10;
  localparam logic [AW-1:0] OFS_PB_DIR  = 8'h14;
  localparam logic [AW-1:0] OFS_PC_DIR  = 8'h18;
  localparam logic [AW-1:0] OFS_PD_DIR  = 8'h1c;
  localparam logic [AW-1:0] OFS_PA_PU   = 8'h20;
  localparam logic [AW-1:0] OFS_PB_PU   = 8'h24;
  localparam logic [AW-1:0] OFS_PC_PU   = 8'h28;
  localparam logic [AW-1:0] OFS_PD_PU   = 8'h2c;
  localparam logic [AW-1:0] OFS_WAKE    = 8'h30;
  localparam logic [AW-1:0] OFS_AUX     = 8'h34;
  localparam logic [AW-1:0] OFS_IRQCTL  = 8'h38;
  localparam logic [AW-1:0] OFS_ALTCTL  = 8'h3c;
  localparam logic [AW-1:0] OFS_ADSEL   = 8'h40;
  localparam logic [AW-1:0] OFS_HALT    = 8'h44;
  localparam logic [AW-1:0] OFS_IRQ_STS = 8'h48;
  localparam logic [AW-1:0] OFS_IRQ_MSK = 8'h4c;
  localparam logic [AW-1:0] OFS_BITOP   = 8'h50;
  // Reset values
  localparam logic [W-1:0] RST_ONES = 8'hff;
  localparam logic [W-1:0] RST_ZERO = 8'h00;
  // Field positions
  localparam int AUX_OD_LSB = 4;
  localparam int IRQCTL_EN0 = 1;
  localparam int IRQCTL_EN1 = 2;
  localparam int EXT0_PIN = 4;
  localparam int EXT1_PIN = 5;
  localparam int DIV_PIN = 3;
  localparam int PWM_PINS = 4;
  localparam int TMR_N = 4;
  localparam int ALT_DIV_EN = 4;
  localparam int BITOP_SET = 8;
  localparam int BITOP_PORT_LSB = 4;
  // Status bits
  localparam int STS_WAKE = 0;
  localparam int STS_EXT0 = 1;
  localparam int STS_EXT1 = 2;
  localparam int STS_W = 3;
  // Sync depth for pins
  localparam int SYNC_N = 3;
  typedef enum logic [1:0] {GPIOA_RUN, GPIOA_DOWN} gpioa_pwr_t;
endpackage : gpioa_pkg

// ===== rtl/gpioa_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module gpioa_sync #(
  parameter int N = 8
) (
  input  wire logic         clk,    // System clock
  input  wire logic         rst_n,  // Async reset, active low
  input  wire logic         ce,     // Clock enable
  input  wire logic [N-1:0] din,    // Raw pin levels
  output logic      [N-1:0] dout    // Filtered level
);
  import gpioa_pkg::*;
  logic [N-1:0] s1;
  logic [N-1:0] s2;
  logic [N-1:0] s3;
  // Three stages and an output flop; output moves once stages two and three agree
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1 <= '1;
      s2 <= '1;
      s3 <= '1;
      dout <= '1;
    end else if (ce) begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
      dout <= (s2 & s3) | (dout & (s2 ^ s3));
    end
  end
endmodule : gpioa_sync
`default_nettype wire

// ===== rtl/gpioa_top.sv
// Four-port general purpose I/O block with APB register access
`timescale 1ns/1ps
`default_nettype none
module gpioa_top (
  input  wire logic                    CLOCK,     // 50 MHz system clock
  input  wire logic                    RST_N,     // Async reset, active low
  input  wire logic                    CE,        // Clock enable
  input  wire logic                    PSEL,      // APB select
  input  wire logic                    PENABLE,   // APB access phase
  input  wire logic                    PWRITE,    // APB write
  input  wire logic [gpioa_pkg::AW-1:0] PADDR,    // APB byte address
  input  wire logic [31:0]             PWDATA,    // APB write data
  output logic      [31:0]             PRDATA,    // APB read data
  output logic                         PREADY,    // APB ready
  output logic                         PSLVERR,   // APB error
  input  wire logic [31:0]             PIN_IN,    // Pin levels, port A low
  output logic      [31:0]             PIN_OUT,   // Pin output values
  output logic      [31:0]             PIN_OE,    // Pin drive enables
  output logic      [31:0]             PIN_PU,    // Pull-high enables
  input  wire logic                    DIV_SIG,   // Divider output source
  input  wire logic                    DIV_OPT,   // Divider option strap
  input  wire logic [3:0]              PWM_SIG,   // PWM sources
  input  wire logic [3:0]              PWM_EN,    // PWM enables
  input  wire logic [3:0]              TMR_EXT,   // Timer ext select
  input  wire logic [3:0]              TMR_PIN,   // Timer pin indices in C
  output logic      [3:0]              TMR_CLK,   // Timer clocks out
  output logic                         EXT_IRQ0,  // Ext irq 0 level
  output logic                         EXT_IRQ1,  // Ext irq 1 level
  output logic                         POWER_DOWN, // Low-power state
  output logic                         WAKE,      // Wake pulse
  output logic                         IRQ        // Interrupt level
);
  import gpioa_pkg::*;

  logic [W-1:0]     data [4];
  logic [W-1:0]     dir [4];
  logic [W-1:0]     pu [4];
  logic [W-1:0]     wake_en;
  logic [W-1:0]     aux;
  logic [W-1:0]     irqctl;
  logic [W-1:0]     altctl;
  logic [W-1:0]     adsel;
  logic [STS_W-1:0] sts;
  logic [STS_W-1:0] msk;
  logic [31:0]      pin_s;
  logic [W-1:0]     pa_prev;
  logic [W-1:0]     ext_prev;
  gpioa_pwr_t       pwr;
  logic             wr;
  logic             rd_ok;
  logic [31:0]      next_rdata;
  logic [1:0]       port;
  logic [W-1:0]     fall;
  logic             wake_ev;
  logic [STS_W-1:0] ev;
  logic [W-1:0]     rmw_val;

  // Port view read: pin for inputs, latch for outputs
  function automatic logic [W-1:0] port_view(input logic [W-1:0] d,
                                             input logic [W-1:0] dr,
                                             input logic [W-1:0] p);
    port_view = (dr & p) | (~dr & d);
  endfunction : port_view

  // Write slot index for a data, direction or pull-up offset
  function automatic logic [1:0] slot(input logic [AW-1:0] a);
    slot = a[3:2];
  endfunction : slot

  // Pins pass the four-flop filter
  gpioa_sync #(.N(32)) u_sync (
    .clk  (CLOCK),
    .rst_n(RST_N),
    .ce   (CE),
    .din  (PIN_IN),
    .dout (pin_s)
  );

  assign wr = PSEL && PENABLE && PWRITE;
  assign PREADY = 1'b1;
  assign port = PWDATA[BITOP_PORT_LSB+1:BITOP_PORT_LSB];

  // Read-modify-write of one data bit from the port view
  always_comb begin
    rmw_val = port_view(data[port], dir[port], pin_s[port*W +: W]);
    rmw_val[PWDATA[2:0]] = PWDATA[BITOP_SET];
  end

  // Data latches, written only by software
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      for (int i = 0; i < 4; i++) data[i] <= RST_ONES;
    end else if (CE && wr) begin
      if (PADDR[AW-1:4] == OFS_PA_DATA[AW-1:4])
        data[slot(PADDR)] <= PWDATA[W-1:0];
      else if (PADDR == OFS_BITOP)
        data[port] <= rmw_val;
    end
  end

  // Direction and pull-up registers
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      for (int i = 0; i < 4; i++) begin
        dir[i] <= RST_ONES;
        pu[i]  <= RST_ZERO;
      end
    end else if (CE && wr) begin
      if (PADDR[AW-1:4] == OFS_PA_DIR[AW-1:4])
        dir[slot(PADDR)] <= PWDATA[W-1:0];
      if (PADDR[AW-1:4] == OFS_PA_PU[AW-1:4])
        pu[slot(PADDR)] <= PWDATA[W-1:0];
    end
  end

  // Wake, auxiliary, alternate-function and mask registers
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      wake_en <= RST_ZERO;
      aux     <= RST_ZERO;
      irqctl  <= RST_ZERO;
      altctl  <= RST_ZERO;
      adsel   <= RST_ZERO;
      msk     <= '0;
    end else if (CE && wr) begin
      case (PADDR)
        OFS_WAKE:    wake_en <= PWDATA[W-1:0];
        OFS_AUX:     aux <= PWDATA[W-1:0];
        OFS_IRQCTL:  irqctl <= PWDATA[W-1:0];
        OFS_ALTCTL:  altctl <= PWDATA[W-1:0];
        OFS_ADSEL:   adsel <= PWDATA[W-1:0];
        OFS_IRQ_MSK: msk <= PWDATA[STS_W-1:0];
        default: ;
      endcase
    end
  end

  // Pin drive: latch, divider, PWM and open-drain
  always_comb begin
    PIN_OUT = {data[3], data[2], data[1], data[0]};
    PIN_OE  = ~{dir[3], dir[2], dir[1], dir[0]};
    if (DIV_OPT && !dir[0][DIV_PIN] && altctl[ALT_DIV_EN])
      PIN_OUT[DIV_PIN] = DIV_SIG;
    for (int i = 0; i < PWM_PINS; i++)
      if (PWM_EN[i] && !dir[3][i])
        PIN_OUT[3*W+i] = PWM_SIG[i];
    for (int i = 0; i < 4; i++)
      if (aux[AUX_OD_LSB+i] && !dir[0][i])
        PIN_OE[i] = ~PIN_OUT[i];
    PIN_OUT[3*W+EXT0_PIN] = PIN_OUT[3*W+EXT0_PIN] &
                            !irqctl[IRQCTL_EN0];
    PIN_OUT[3*W+EXT1_PIN] = PIN_OUT[3*W+EXT1_PIN] &
                            !irqctl[IRQCTL_EN1];
    if (irqctl[IRQCTL_EN0]) PIN_OE[3*W+EXT0_PIN] = 1'b0;
    if (irqctl[IRQCTL_EN1]) PIN_OE[3*W+EXT1_PIN] = 1'b0;
    PIN_PU = {pu[3] & dir[3], pu[2] & dir[2],
              pu[1] & dir[1] & ~adsel, pu[0] & dir[0]};
  end

  // Timer clocks from port C pins when selected and input
  always_comb begin
    for (int i = 0; i < TMR_N; i++)
      TMR_CLK[i] = TMR_EXT[i] && dir[2][TMR_PIN[i]] &&
                   pin_s[2*W+TMR_PIN[i]];
  end

  assign EXT_IRQ0 = irqctl[IRQCTL_EN0] && pin_s[3*W+EXT0_PIN];
  assign EXT_IRQ1 = irqctl[IRQCTL_EN1] && pin_s[3*W+EXT1_PIN];

  // Falling edge detect on port A and ext irq pins
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      pa_prev  <= RST_ONES;
      ext_prev <= RST_ONES;
    end else if (CE) begin
      pa_prev  <= pin_s[W-1:0];
      ext_prev <= pin_s[3*W +: W];
    end
  end
  assign fall = pa_prev & ~pin_s[W-1:0] & wake_en;

  // Power-down state: halt write enters, enabled edge leaves
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      pwr <= GPIOA_RUN;
    end else if (CE) begin
      case (pwr)
        GPIOA_RUN:  if (wr && PADDR == OFS_HALT) pwr <= GPIOA_DOWN;
        GPIOA_DOWN: if (|fall) pwr <= GPIOA_RUN;
        default:    pwr <= GPIOA_RUN;
      endcase
    end
  end
  assign POWER_DOWN = (pwr == GPIOA_DOWN);
  assign wake_ev = POWER_DOWN && (|fall);
  assign WAKE = wake_ev && CE;

  // Sticky status; set wins over write-one clear
  assign ev[STS_WAKE] = wake_ev;
  assign ev[STS_EXT0] = irqctl[IRQCTL_EN0] && ext_prev[EXT0_PIN] &&
                        !pin_s[3*W+EXT0_PIN];
  assign ev[STS_EXT1] = irqctl[IRQCTL_EN1] && ext_prev[EXT1_PIN] &&
                        !pin_s[3*W+EXT1_PIN];
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      sts <= '0;
    end else if (CE) begin
      if (wr && PADDR == OFS_IRQ_STS)
        sts <= (sts & ~PWDATA[STS_W-1:0]) | ev;
      else
        sts <= sts | ev;
    end
  end
  assign IRQ = |(sts & msk);

  // Read decode, sampled in the setup cycle
  always_comb begin
    next_rdata = '0;
    rd_ok = 1'b1;
    if (PADDR[AW-1:4] == OFS_PA_DATA[AW-1:4])
      next_rdata[W-1:0] = port_view(data[slot(PADDR)], dir[slot(PADDR)],
                                    pin_s[slot(PADDR)*W +: W]);
    else if (PADDR[AW-1:4] == OFS_PA_DIR[AW-1:4])
      next_rdata[W-1:0] = dir[slot(PADDR)];
    else if (PADDR[AW-1:4] == OFS_PA_PU[AW-1:4])
      next_rdata[W-1:0] = pu[slot(PADDR)];
    else begin
      case (PADDR)
        OFS_WAKE:    next_rdata[W-1:0] = wake_en;
        OFS_AUX:     next_rdata[W-1:0] = aux;
        OFS_IRQCTL:  next_rdata[W-1:0] = irqctl;
        OFS_ALTCTL:  next_rdata[W-1:0] = altctl;
        OFS_ADSEL:   next_rdata[W-1:0] = adsel;
        OFS_HALT:    next_rdata[0] = POWER_DOWN;
        OFS_IRQ_STS: next_rdata[STS_W-1:0] = sts;
        OFS_IRQ_MSK: next_rdata[STS_W-1:0] = msk;
        OFS_BITOP:   next_rdata = '0;
        default:     rd_ok = 1'b0;
      endcase
    end
  end
  // Read data captured in the setup cycle, held through access
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      PRDATA <= '0;
    end else if (CE && PSEL && !PENABLE && !PWRITE) begin
      PRDATA <= next_rdata;
    end
  end
  assign PSLVERR = PSEL && PENABLE && !rd_ok;

  // Checks on pin drive and state
  property p_out_follows;
    @(posedge CLOCK) disable iff (!RST_N)
      (!dir[1][0]) |-> (PIN_OE[W] && PIN_OUT[W] == data[1][0]);
  endproperty
  a_out_follows: assert property (p_out_follows)
    else $error("port B bit 0 output not driven from latch");

  property p_in_no_drive;
    @(posedge CLOCK) disable iff (!RST_N)
      dir[2][0] |-> !PIN_OE[2*W];
  endproperty
  a_in_no_drive: assert property (p_in_no_drive)
    else $error("input pin driven");

  property p_pu_input;
    @(posedge CLOCK) disable iff (!RST_N)
      PIN_PU[3*W] |-> (dir[3][0] && pu[3][0]);
  endproperty
  a_pu_input: assert property (p_pu_input)
    else $error("pull-high on output pin");

  property p_adc_pu;
    @(posedge CLOCK) disable iff (!RST_N)
      adsel[0] |-> !PIN_PU[W];
  endproperty
  a_adc_pu: assert property (p_adc_pu)
    else $error("pull-high on analog pin");

  property p_wake;
    @(posedge CLOCK) disable iff (!RST_N)
      (CE && POWER_DOWN && |fall) |=> !POWER_DOWN;
  endproperty
  a_wake: assert property (p_wake)
    else $error("no wake on enabled falling edge");

  property p_stay_down;
    @(posedge CLOCK) disable iff (!RST_N)
      (POWER_DOWN && !(|fall)) |=> POWER_DOWN;
  endproperty
  a_stay_down: assert property (p_stay_down)
    else $error("left power-down without edge");

  property p_latch_hold;
    @(posedge CLOCK) disable iff (!RST_N)
      !(wr && PADDR[AW-1:4] == OFS_PA_DATA[AW-1:4]) &&
      !(wr && PADDR == OFS_BITOP) |=> $stable(data[0]);
  endproperty
  a_latch_hold: assert property (p_latch_hold)
    else $error("data latch changed without write");

  property p_od;
    @(posedge CLOCK) disable iff (!RST_N)
      (aux[AUX_OD_LSB] && !dir[0][0] && PIN_OUT[0]) |-> !PIN_OE[0];
  endproperty
  a_od: assert property (p_od)
    else $error("open-drain pin drove high");

  property p_ext_io;
    @(posedge CLOCK) disable iff (!RST_N)
      irqctl[IRQCTL_EN0] |-> !PIN_OE[3*W+EXT0_PIN];
  endproperty
  a_ext_io: assert property (p_ext_io)
    else $error("irq pin driven");

  property p_rd_latch;
    @(posedge CLOCK) disable iff (!RST_N)
      (CE && PSEL && !PENABLE && !PWRITE && PADDR == OFS_PA_DATA &&
       dir[0] == RST_ZERO) |=> (PRDATA[W-1:0] == $past(data[0]));
  endproperty
  a_rd_latch: assert property (p_rd_latch)
    else $error("output port read did not return latch");

  property p_pwm;
    @(posedge CLOCK) disable iff (!RST_N)
      (PWM_EN[0] && !dir[3][0]) |->
        (PIN_OE[3*W] && PIN_OUT[3*W] == PWM_SIG[0]);
  endproperty
  a_pwm: assert property (p_pwm)
    else $error("PWM not on output pin");

  property p_div;
    @(posedge CLOCK) disable iff (!RST_N)
      (DIV_OPT && altctl[ALT_DIV_EN] && !dir[0][DIV_PIN]) |->
        (PIN_OUT[DIV_PIN] == DIV_SIG);
  endproperty
  a_div: assert property (p_div)
    else $error("divider not on output pin");

  property p_tmr_in;
    @(posedge CLOCK) disable iff (!RST_N)
      TMR_CLK[0] |-> (TMR_EXT[0] && dir[2][TMR_PIN[0]]);
  endproperty
  a_tmr_in: assert property (p_tmr_in)
    else $error("timer clock from non-input pin");

  property p_ext_sts;
    @(posedge CLOCK) disable iff (!RST_N)
      (CE && ev[STS_EXT0]) |=> sts[STS_EXT0];
  endproperty
  a_ext_sts: assert property (p_ext_sts)
    else $error("falling edge status not set");
endmodule : gpioa_top
`default_nettype wire

// ===== sim/gpioa_tb_top.sv
// Self-checking testbench of the four-port I/O block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin \
  miscompares++; $display("BAD %0t got %h exp %h", $time, g, e); end end
module gpioa_tb_top;
  import gpioa_pkg::*;
  logic          CLOCK;
  logic          RST_N;
  logic          CE;
  logic          PSEL;
  logic          PENABLE;
  logic          PWRITE;
  logic [AW-1:0] PADDR;
  logic [31:0]   PWDATA;
  logic [31:0]   PRDATA;
  logic          PREADY;
  logic          PSLVERR;
  logic [31:0]   PIN_IN;
  logic [31:0]   PIN_OUT;
  logic [31:0]   PIN_OE;
  logic [31:0]   PIN_PU;
  logic          DIV_SIG;
  logic          DIV_OPT;
  logic [3:0]    PWM_SIG;
  logic [3:0]    PWM_EN;
  logic [3:0]    TMR_EXT;
  logic [3:0]    TMR_PIN;
  logic [3:0]    TMR_CLK;
  logic          EXT_IRQ0;
  logic          EXT_IRQ1;
  logic          POWER_DOWN;
  logic          WAKE;
  logic          IRQ;
  logic [31:0]   rdat;
  logic          rerr;
  int            miscompares;
  int            check_count;
  int            k;

  gpioa_top gpioa_top_inst (
    .CLOCK(CLOCK), .RST_N(RST_N), .CE(CE), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .PIN_IN(PIN_IN), .PIN_OUT(PIN_OUT),
    .PIN_OE(PIN_OE), .PIN_PU(PIN_PU), .DIV_SIG(DIV_SIG), .DIV_OPT(DIV_OPT),
    .PWM_SIG(PWM_SIG), .PWM_EN(PWM_EN), .TMR_EXT(TMR_EXT),
    .TMR_PIN(TMR_PIN), .TMR_CLK(TMR_CLK), .EXT_IRQ0(EXT_IRQ0),
    .EXT_IRQ1(EXT_IRQ1), .POWER_DOWN(POWER_DOWN), .WAKE(WAKE), .IRQ(IRQ)
  );

  // 50 MHz clock
  initial begin
    CLOCK = 1'b0;
    forever #10 CLOCK = ~CLOCK;
  end

  // Verdict and end of run
  task automatic close_out;
    if (miscompares == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : close_out

  // One APB transfer, held until pready is seen high
  task automatic apb(input logic w, input logic [AW-1:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge CLOCK);
    PSEL    <= 1'b1;
    PWRITE  <= w;
    PADDR   <= a;
    PWDATA  <= d;
    PENABLE <= 1'b0;
    @(posedge CLOCK);
    PENABLE <= 1'b1;
    n = 0;
    do begin
      @(posedge CLOCK);
      n++;
    end while (PREADY !== 1'b1 && n < 50);
    if (n >= 50) miscompares++;
    rdat = PRDATA;
    rerr = PSLVERR;
    PSEL    <= 1'b0;
    PENABLE <= 1'b0;
  endtask : apb

  task automatic wr(input logic [AW-1:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [AW-1:0] a);
    apb(1'b0, a, 32'h0);
  endtask : rd

  // Let pin synchronisers and register updates land
  task automatic settle(input int n);
    repeat (n) @(posedge CLOCK);
    #1;
  endtask : settle

  // Hang guard
  initial begin
    #400000;
    miscompares++;
    close_out();
  end

  // Main sequence
  initial begin
    RST_N = 1'b0; CE = 1'b1; PSEL = 1'b0; PENABLE = 1'b0; PWRITE = 1'b0;
    PADDR = '0; PWDATA = '0; PIN_IN = 32'hffff_ffff;
    DIV_SIG = 1'b1; DIV_OPT = 1'b1;
    PWM_SIG = 4'ha; PWM_EN = 4'h0; TMR_EXT = 4'h1; TMR_PIN = 4'h0;
    miscompares = 0;
    check_count = 0;
    repeat (5) @(posedge CLOCK);
    RST_N <= 1'b1;
    // Reset values of data port reads (pin levels, all pins inputs), directions and the port A pull-high
    for (k = 0; k < 8; k++) begin
      rd(8'(k * 4));
      `CHK(rdat, 32'h0000_00ff)
    end
    rd(OFS_PA_PU);
    `CHK(rdat, 32'h0)
    settle(1);
    `CHK(PIN_OE, 32'h0)
    // Ignored write while the clock enable is low
    @(posedge CLOCK);
    CE <= 1'b0;
    wr(OFS_PC_DATA, 32'h12);
    CE <= 1'b1;
    rd(OFS_PC_DATA);
    `CHK(rdat, 32'hff)
    settle(1);
    `CHK(PIN_OUT[23:16], 8'hff)
    // Port A output reads back the latch, not the pins
    @(posedge CLOCK);
    PIN_IN[7:0] <= 8'ha5;
    wr(OFS_PA_DIR, 32'h00);
    settle(1);
    `CHK(PIN_OUT[7:0], 8'hff)
    wr(OFS_PA_DATA, 32'h5a);
    settle(6);
    `CHK(PIN_OUT[7:0], 8'h5a)
    `CHK(PIN_OE[7:0], 8'hff)
    rd(OFS_PA_DATA);
    `CHK(rdat[7:0], 8'h5a)
    // Port B mixed direction read
    @(posedge CLOCK);
    PIN_IN[15:8] <= 8'hc3;
    settle(6);
    rd(OFS_PB_DATA);
    `CHK(rdat[7:0], 8'hc3)
    wr(OFS_PB_DIR, 32'h0f);
    rd(OFS_PB_DATA);
    `CHK(rdat[7:0], 8'hf3)
    // Pull-highs: input only, dropped on analog pins
    wr(OFS_PB_DIR, 32'hff);
    wr(OFS_PB_PU, 32'hff);
    settle(1);
    `CHK(PIN_PU[15:8], 8'hff)
    wr(OFS_ADSEL, 32'h0f);
    settle(1);
    `CHK(PIN_PU[15:8], 8'hf0)
    wr(OFS_ADSEL, 32'h00);
    wr(OFS_PB_DIR, 32'h3c);
    settle(1);
    `CHK(PIN_PU[15:8], 8'h3c)
    // Open drain on PA0-PA3 drives only low levels
    wr(OFS_PA_DATA, 32'h0a);
    wr(OFS_AUX, 32'hf0);
    settle(1);
    `CHK(PIN_OE[7:0], 8'hf5)
    wr(OFS_AUX, 32'h00);
    // Bit set on port A as read-modify-write
    wr(OFS_BITOP, 32'h102);
    rd(OFS_PA_DATA);
    `CHK(rdat[7:0], 8'h0e)
    // Divider on PA3 only while PA3 is an output
    wr(OFS_ALTCTL, 32'h10);
    @(posedge CLOCK);
    DIV_SIG <= 1'b0;
    settle(1);
    `CHK(PIN_OUT[3], 1'b0)
    wr(OFS_PA_DIR, 32'h08);
    settle(1);
    `CHK(PIN_OE[3], 1'b0)
    wr(OFS_ALTCTL, 32'h00);
    // PWM on PD0-PD3 only while outputs
    wr(OFS_PD_DIR, 32'hf0);
    @(posedge CLOCK);
    PWM_EN <= 4'hf;
    settle(1);
    `CHK(PIN_OUT[27:24], 4'ha)
    wr(OFS_PD_DIR, 32'hff);
    settle(1);
    `CHK(PIN_OE[27:24], 4'h0)
    // Timer clock from PC0 only while input
    @(posedge CLOCK);
    PIN_IN[16] <= 1'b0;
    settle(6);
    `CHK(TMR_CLK[0], 1'b0)
    @(posedge CLOCK);
    PIN_IN[16] <= 1'b1;
    settle(6);
    `CHK(TMR_CLK[0], 1'b1)
    wr(OFS_PC_DIR, 32'hfe);
    settle(1);
    `CHK(TMR_CLK[0], 1'b0)
    // External irq pins, falling edge status, mask and clear
    wr(OFS_IRQCTL, 32'h06);
    @(posedge CLOCK);
    PIN_IN[29:28] <= 2'b11;
    settle(6);
    `CHK(EXT_IRQ0, 1'b1)
    `CHK(EXT_IRQ1, 1'b1)
    @(posedge CLOCK);
    PIN_IN[28] <= 1'b0;
    settle(6);
    rd(OFS_IRQ_STS);
    `CHK(rdat, 32'h2)
    `CHK(IRQ, 1'b0)
    wr(OFS_IRQ_MSK, 32'h07);
    settle(1);
    `CHK(IRQ, 1'b1)
    wr(OFS_IRQ_STS, 32'h2);
    settle(1);
    `CHK(IRQ, 1'b0)
    wr(OFS_IRQCTL, 32'h00);
    settle(1);
    `CHK(EXT_IRQ1, 1'b0)
    // Wake from power-down on an enabled port A pin only
    @(posedge CLOCK);
    PIN_IN[7:0] <= 8'hff;
    settle(6);
    wr(OFS_WAKE, 32'h01);
    wr(OFS_HALT, 32'h01);
    settle(1);
    `CHK(POWER_DOWN, 1'b1)
    @(posedge CLOCK);
    PIN_IN[1] <= 1'b0;
    settle(10);
    `CHK(POWER_DOWN, 1'b1)
    @(posedge CLOCK);
    PIN_IN[0] <= 1'b0;
    k = 0;
    while (POWER_DOWN !== 1'b0 && k < 20) begin
      settle(1);
      k++;
    end
    `CHK(POWER_DOWN, 1'b0)
    `CHK(IRQ, 1'b1)
    rd(OFS_IRQ_STS);
    `CHK(rdat, 32'h1)
    // Unmapped address
    rd(8'hfc);
    `CHK(rerr, 1'b1)
    `CHK(rdat, 32'h0)
    close_out();
  end
endmodule : gpioa_tb_top
`default_nettype wire
